// >>> include/fpmc_pkg.sv
// Constants and types of the flash protect/mode host controller.
// Assumes a 250 MHz core clock and an asynchronous x16 parallel flash on the pins.
package fpmc_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 20;                // Word address width
  localparam int DATA_W = 16;                // Data bus width
  localparam int CNT_W = 12;                 // Timing counter width
  localparam int IDX_W = 3;                  // Command cycle index width
  localparam int TOGGLE_BIT = 6;             // Position of the toggle status bit

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;          // Core clock period
  localparam int WRITE_PULSE_NS = 40;        // Strobe low time
  localparam int WRITE_GAP_NS = 30;          // Strobe high time between cycles
  localparam int READ_CYCLE_TIME_NS = 70;    // Read cycle time
  localparam int RESET_PULSE_MIN_NS = 500;   // Reset pin low time
  localparam int RESET_RECOVERY_TIME_NS = 50; // Recovery after reset release
  localparam int SYNC_LAT = 4;               // Cycles through the pin synchroniser

  localparam logic [CNT_W-1:0] WRITE_PULSE_CYC =
    CNT_W'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WRITE_GAP_CYC =
    CNT_W'((WRITE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] READ_CYC =
    CNT_W'((READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT);
  localparam logic [CNT_W-1:0] RESET_PULSE_CYC =
    CNT_W'((RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESET_RECOVERY_CYC =
    CNT_W'((RESET_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ------------------------------------------------------------
  // Command table
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 20'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 20'h002aa;
  localparam logic [ADDR_W-1:0] SHORT_CFI_ADDR = 20'h00055;
  localparam logic [ADDR_W-1:0] ZERO_ADDR = 20'h00000;
  localparam logic [7:0] UNLOCK_CODE1 = 8'haa;
  localparam logic [7:0] UNLOCK_CODE2 = 8'h55;
  localparam logic [7:0] PROGRAM_CODE = 8'ha0;
  localparam logic [7:0] ERASE_SETUP_CODE = 8'h80;
  localparam logic [7:0] SECTOR_ERASE_CODE = 8'h30;
  localparam logic [7:0] BLOCK_ERASE_CODE = 8'h50;
  localparam logic [7:0] CHIP_ERASE_CODE = 8'h10;
  localparam logic [7:0] ID_ENTRY_CODE = 8'h90;
  localparam logic [7:0] CFI_ENTRY_CODE = 8'h98;
  localparam logic [7:0] SHORT_CFI_CODE = 8'h89;
  localparam logic [7:0] SEC_ENTRY_CODE = 8'h88;
  localparam logic [7:0] EXIT_CODE = 8'hf0;
  localparam logic [7:0] SEC_PROGRAM_CODE = 8'ha5;
  localparam logic [7:0] SEC_LOCK_CODE = 8'h85;
  localparam logic [DATA_W-1:0] SEC_LOCK_DATA = 16'h0000;

  // Boot block bounds and identification read addresses
  localparam logic [ADDR_W-1:0] BOTTOM_BOOT_LAST = 20'h01fff;
  localparam logic [ADDR_W-1:0] TOP_BOOT_FIRST = 20'hfe000;
  localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 20'h00000;
  localparam logic [ADDR_W-1:0] ID_DEVICE_ADDR = 20'h00001;

  // ------------------------------------------------------------
  // User operations
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ        = 4'h0,
    OP_PROGRAM     = 4'h1,
    OP_SECTOR_ERASE = 4'h2,
    OP_BLOCK_ERASE = 4'h3,
    OP_CHIP_ERASE  = 4'h4,
    OP_ID_ENTRY    = 4'h5,
    OP_CFI_ENTRY   = 4'h6,
    OP_CFI_SHORT   = 4'h7,
    OP_SEC_ENTRY   = 4'h8,
    OP_EXIT        = 4'h9,
    OP_SEC_PROGRAM = 4'ha,
    OP_SEC_LOCK    = 4'hb,
    OP_HW_RESET    = 4'hc
  } fpmc_op_type;

  // User request
  typedef struct packed {
    fpmc_op_type op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fpmc_req_type;

  // One bus write cycle
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fpmc_cyc_type;

  // Flash pin outputs
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic wp_n;
    logic dq_oe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
  } fpmc_pins_type;

  localparam fpmc_pins_type PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1,
    wp_n: 1'b1, dq_oe: 1'b0, addr: '0, dq_o: '0};

endpackage : fpmc_pkg

// >>> hdl/fpmc_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the inputs are asynchronous to CORE_CLK.
`timescale 1ns/1ps
`default_nettype none
module fpmc_sync #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output var logic [W-1:0] dout
);

  // ------------------------------------------------------------
  // Stages
  // ------------------------------------------------------------
  logic [W-1:0] s1_ff;    // First stage, read only by s2
  logic [W-1:0] s2_ff;    // Second stage
  logic [W-1:0] s3_ff;    // Third stage
  logic [W-1:0] out_ff;   // Filtered value
  logic [W-1:0] nxt_out;

  // Take a bit over once the second and third stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
    end
  end

  // Register the chain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign dout = out_ff;

endmodule : fpmc_sync
`default_nettype wire

// >>> hdl/fpmc_host.sv
// Host controller that drives a x16 parallel flash through its pins.
// Assumes one request at a time and a flash wired to the pins.
`timescale 1ns/1ps
`default_nettype none
module fpmc_host
  import fpmc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic REQ_VALID,
  input wire fpmc_req_type REQ,
  output var logic REQ_READY,
  output var logic RSP_VALID,
  output var logic [DATA_W-1:0] RSP_DATA,
  input wire logic PROTECT_BOOT,
  input wire logic [DATA_W-1:0] FL_DQ_I,
  output var fpmc_pins_type PINS
);

  // ------------------------------------------------------------
  // Command table helpers
  // ------------------------------------------------------------
  // Command word with the upper byte held low
  function automatic logic [DATA_W-1:0] cmd_word(input logic [7:0] code);
    cmd_word = {8'h00, code};
  endfunction : cmd_word

  // Write cycles of an operation
  function automatic logic [IDX_W-1:0] num_writes(input fpmc_op_type op);
    unique case (op)
      OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE: num_writes = 3'd6;
      OP_PROGRAM, OP_SEC_PROGRAM, OP_SEC_LOCK: num_writes = 3'd4;
      OP_CFI_SHORT: num_writes = 3'd1;
      OP_READ, OP_HW_RESET: num_writes = 3'd0;
      default: num_writes = 3'd3;
    endcase
  endfunction : num_writes

  // Operations that must be polled
  function automatic logic needs_poll(input fpmc_op_type op);
    needs_poll = (op == OP_PROGRAM) || (op == OP_SEC_PROGRAM) || (op == OP_SEC_LOCK) ||
      (op == OP_SECTOR_ERASE) || (op == OP_BLOCK_ERASE) || (op == OP_CHIP_ERASE);
  endfunction : needs_poll

  // Address and data of write cycle idx
  function automatic fpmc_cyc_type cmd_cycle(input fpmc_req_type r, input logic [IDX_W-1:0] idx);
    logic [7:0] third;
    logic [7:0] last;
    fpmc_cyc_type c;
    unique case (r.op)
      OP_PROGRAM: third = PROGRAM_CODE;
      OP_SEC_PROGRAM: third = SEC_PROGRAM_CODE;
      OP_SEC_LOCK: third = SEC_LOCK_CODE;
      OP_ID_ENTRY: third = ID_ENTRY_CODE;
      OP_CFI_ENTRY: third = CFI_ENTRY_CODE;
      OP_SEC_ENTRY: third = SEC_ENTRY_CODE;
      OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE: third = ERASE_SETUP_CODE;
      default: third = EXIT_CODE;
    endcase
    unique case (r.op)
      OP_BLOCK_ERASE: last = BLOCK_ERASE_CODE;
      OP_CHIP_ERASE: last = CHIP_ERASE_CODE;
      default: last = SECTOR_ERASE_CODE;
    endcase
    unique case (idx)
      3'd0: c = '{addr: UNLOCK_ADDR1, data: cmd_word(UNLOCK_CODE1)};
      3'd1: c = '{addr: UNLOCK_ADDR2, data: cmd_word(UNLOCK_CODE2)};
      3'd2: c = '{addr: UNLOCK_ADDR1, data: cmd_word(third)};
      3'd3: begin
        if (r.op == OP_SEC_LOCK) begin
          c = '{addr: ZERO_ADDR, data: SEC_LOCK_DATA};
        end else if (needs_poll(r.op) && num_writes(r.op) == 3'd4) begin
          c = '{addr: r.addr, data: r.data}; // Data word, full width
        end else begin
          c = '{addr: UNLOCK_ADDR1, data: cmd_word(UNLOCK_CODE1)};
        end
      end
      3'd4: c = '{addr: UNLOCK_ADDR2, data: cmd_word(UNLOCK_CODE2)};
      default: begin
        if (r.op == OP_CHIP_ERASE) begin
          c = '{addr: UNLOCK_ADDR1, data: cmd_word(last)};
        end else begin
          c = '{addr: r.addr, data: cmd_word(last)};
        end
      end
    endcase
    if (r.op == OP_CFI_SHORT) begin
      c = '{addr: SHORT_CFI_ADDR, data: cmd_word(SHORT_CFI_CODE)};
    end
    cmd_cycle = c;
  endfunction : cmd_cycle

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_WR_SET   = 4'h1,
    ST_WR_PULSE = 4'h2,
    ST_WR_GAP   = 4'h3,
    ST_RD       = 4'h4,
    ST_POLL_RD  = 4'h5,
    ST_POLL_GAP = 4'h6,
    ST_RST_LOW  = 4'h7,
    ST_RST_REC  = 4'h8,
    ST_DONE     = 4'h9
  } fpmc_state_type;

  fpmc_state_type state_ff, nxt_state;       // Sequencer state
  fpmc_req_type req_ff, nxt_req;             // Latched request
  logic [IDX_W-1:0] idx_ff, nxt_idx;         // Write cycle index
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;         // Phase timer
  logic prev_ff, nxt_prev;                   // Previous toggle bit
  logic have_prev_ff, nxt_have_prev;         // A first poll read exists
  logic [DATA_W-1:0] rsp_data_ff, nxt_rsp_data; // Read result
  logic rsp_valid_ff, nxt_rsp_valid;         // Result pulse
  logic ready_ff, nxt_ready;                 // Accepting requests
  fpmc_pins_type pins_ff, nxt_pins;          // Pin outputs
  logic [DATA_W-1:0] dq_sync;                // Synchronised read data
  fpmc_cyc_type cur_cyc;                     // Current write cycle

  // ------------------------------------------------------------
  // Pin input synchroniser
  // ------------------------------------------------------------
  fpmc_sync #(.W(DATA_W)) u_dq_sync (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .din(FL_DQ_I),
    .dout(dq_sync)
  );

  assign cur_cyc = cmd_cycle(req_ff, idx_ff);

  // ------------------------------------------------------------
  // Sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_idx = idx_ff;
    nxt_cnt = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
    nxt_prev = prev_ff;
    nxt_have_prev = have_prev_ff;
    nxt_rsp_data = rsp_data_ff;
    nxt_rsp_valid = 1'b0;
    unique case (state_ff)
      // Wait for a request; exit only goes out here
      ST_IDLE: begin
        if (REQ_VALID) begin
          nxt_req = REQ;
          nxt_idx = '0;
          nxt_have_prev = 1'b0;
          if (REQ.op == OP_HW_RESET) begin
            nxt_state = ST_RST_LOW;
            nxt_cnt = RESET_PULSE_CYC - 1'b1;
          end else if (REQ.op == OP_READ) begin
            nxt_state = ST_RD;
            nxt_cnt = READ_CYC - 1'b1;
          end else begin
            nxt_state = ST_WR_SET;
          end
        end
      end
      // Address and data settle before the strobe falls
      ST_WR_SET: begin
        nxt_state = ST_WR_PULSE;
        nxt_cnt = WRITE_PULSE_CYC - 1'b1;
      end
      // Strobe low for the full pulse time
      ST_WR_PULSE: begin
        if (cnt_ff == '0) begin
          nxt_state = ST_WR_GAP;
          nxt_cnt = WRITE_GAP_CYC - 1'b1;
        end
      end
      // Strobes high; then next cycle, poll or finish
      ST_WR_GAP: begin
        if (cnt_ff == '0) begin
          if (idx_ff + 1'b1 < num_writes(req_ff.op)) begin
            nxt_idx = idx_ff + 1'b1;
            nxt_state = ST_WR_SET;
          end else if (needs_poll(req_ff.op)) begin
            nxt_state = ST_POLL_RD;
            nxt_cnt = READ_CYC - 1'b1;
          end else begin
            nxt_state = ST_DONE;
          end
        end
      end
      // Single read
      ST_RD: begin
        if (cnt_ff == '0) begin
          nxt_rsp_data = dq_sync;
          nxt_state = ST_DONE;
        end
      end
      // Poll the toggle bit until two reads agree
      ST_POLL_RD: begin
        if (cnt_ff == '0) begin
          nxt_rsp_data = dq_sync;
          nxt_prev = dq_sync[TOGGLE_BIT];
          nxt_have_prev = 1'b1;
          if (have_prev_ff && dq_sync[TOGGLE_BIT] == prev_ff) begin
            nxt_state = ST_DONE;
          end else begin
            nxt_state = ST_POLL_GAP;
            nxt_cnt = WRITE_GAP_CYC - 1'b1;
          end
        end
      end
      // Output enable high between polls
      ST_POLL_GAP: begin
        if (cnt_ff == '0) begin
          nxt_state = ST_POLL_RD;
          nxt_cnt = READ_CYC - 1'b1;
        end
      end
      // Reset pin held low
      ST_RST_LOW: begin
        if (cnt_ff == '0) begin
          nxt_state = ST_RST_REC;
          nxt_cnt = RESET_RECOVERY_CYC - 1'b1;
        end
      end
      // Reset recovery
      ST_RST_REC: begin
        if (cnt_ff == '0) begin
          nxt_state = ST_DONE;
        end
      end
      // Report completion
      ST_DONE: begin
        nxt_rsp_valid = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    nxt_ready = (nxt_state == ST_IDLE);
  end

  // ------------------------------------------------------------
  // Pin next values
  // ------------------------------------------------------------
  always_comb begin
    nxt_pins = PINS_IDLE;
    nxt_pins.wp_n = ~PROTECT_BOOT;
    nxt_pins.addr = pins_ff.addr;
    nxt_pins.dq_o = pins_ff.dq_o;
    unique case (state_ff)
      // Write phases
      ST_WR_SET, ST_WR_PULSE: begin
        nxt_pins.ce_n = 1'b0;
        nxt_pins.dq_oe = 1'b1;
        nxt_pins.addr = cur_cyc.addr;
        nxt_pins.dq_o = cur_cyc.data;
        nxt_pins.we_n = (state_ff != ST_WR_PULSE); // Full pulse time
      end
      // Data held after the strobe rises
      ST_WR_GAP: begin
        nxt_pins.dq_oe = 1'b1;
      end
      // Read phases
      ST_RD, ST_POLL_RD: begin
        nxt_pins.ce_n = 1'b0;
        nxt_pins.oe_n = 1'b0;
        nxt_pins.addr = req_ff.addr;
      end
      ST_RST_LOW: begin
        nxt_pins.rst_n = 1'b0;
      end
      default: begin
        nxt_pins.dq_oe = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      state_ff <= ST_IDLE;
      req_ff <= '0;
      idx_ff <= '0;
      cnt_ff <= '0;
      prev_ff <= 1'b0;
      have_prev_ff <= 1'b0;
      rsp_data_ff <= '0;
      rsp_valid_ff <= 1'b0;
      ready_ff <= 1'b0;
      pins_ff <= PINS_IDLE;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      idx_ff <= nxt_idx;
      cnt_ff <= nxt_cnt;
      prev_ff <= nxt_prev;
      have_prev_ff <= nxt_have_prev;
      rsp_data_ff <= nxt_rsp_data;
      rsp_valid_ff <= nxt_rsp_valid;
      ready_ff <= nxt_ready;
      pins_ff <= nxt_pins;
    end
  end

  assign REQ_READY = ready_ff;
  assign RSP_VALID = rsp_valid_ff;
  assign RSP_DATA = rsp_data_ff;
  assign PINS = pins_ff;

endmodule : fpmc_host
`default_nettype wire

// >>> tb/fpmc_host_properties.sv
// Concurrent checks on the pins and handshake of the flash host controller.
// Assumes binding to fpmc_host; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fpmc_host_properties
  import fpmc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire logic PROTECT_BOOT,
  input wire fpmc_pins_type PINS
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic [CNT_W-1:0] low_cnt_ff; // Reset pin low cycles
  logic [CNT_W-1:0] nxt_low_cnt; // Next count

  // Counts reset pin low cycles
  always_comb begin
    nxt_low_cnt = PINS.rst_n ? '0 : low_cnt_ff + CNT_W'(1);
  end

  // Registers the count
  always_ff @(posedge CORE_CLK) begin
    low_cnt_ff <= RESET_N ? nxt_low_cnt : '0;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  write_inhibit_a: assert property (!PINS.we_n |-> PINS.oe_n && !PINS.ce_n && PINS.dq_oe)
    else $error("Write outside write inhibit");
  read_strobe_a: assert property (!PINS.oe_n |-> !PINS.ce_n && PINS.we_n && !PINS.dq_oe)
    else $error("Read strobe during write");
  we_pulse_a: assert property ($fell(PINS.we_n) |-> !PINS.we_n [*8] ##1 !PINS.we_n [*2])
    else $error("Write pulse short");
  we_gap_a: assert property ($rose(PINS.we_n) |-> PINS.we_n [*8])
    else $error("Write gap short");
  boot_protect_a: assert property (PROTECT_BOOT |=> !PINS.wp_n)
    else $error("Protect pin late");
  rst_pulse_a: assert property ($rose(PINS.rst_n) |-> low_cnt_ff >= RESET_PULSE_CYC)
    else $error("Reset pulse short");
  rst_recover_a: assert property ($rose(PINS.rst_n) |-> PINS.oe_n [*8] ##1 PINS.oe_n [*5])
    else $error("Read in reset recovery");
  upper_byte_a: assert property (!PINS.we_n && PINS.addr == UNLOCK_ADDR2
    |-> PINS.dq_o[15:8] == 8'h00)
    else $error("Upper byte not low");
  reset_idle_a: assert property ($rose(RESET_N) |-> PINS == PINS_IDLE && !REQ_READY
    && !RSP_VALID ##1 REQ_READY)
    else $error("Bad state after reset");
endmodule : fpmc_host_properties

bind fpmc_host fpmc_host_properties i_fpmc_host_properties (.CORE_CLK(CORE_CLK),
  .RESET_N(RESET_N), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
  .PROTECT_BOOT(PROTECT_BOOT), .PINS(PINS));
`default_nettype wire

// >>> tb/fpmc_flash_model.sv
// Behavioural x16 parallel flash model.
// Assumes pins sampled on the core clock; no pull on the data lines.
`timescale 1ns/1ps
`default_nettype none
module fpmc_flash_model
  import fpmc_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h005a, // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h7c31, // Arbitrary value
  parameter bit BOOT_AT_TOP = 1'b0 // Variant: bottom boot block
) (
  input wire logic clk,
  input wire fpmc_pins_type pins,
  output var logic [DATA_W-1:0] dq
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  localparam int M_ARR = 0, M_ID = 1, M_CFI = 2, M_SEC = 3; // Read modes
  logic [15:0] mem [int]; // Array words
  logic [15:0] sec [0:135]; // Security area
  fpmc_pins_type p; // Pins one clock earlier
  int stg, mode, busy, lowc; // Step, mode, busy reads, strobe low time
  logic tog, locked; // Toggle status bit, user segment locked

  initial begin
    dq = '0;
    p = PINS_IDLE;
    {stg, mode, busy, lowc, tog, locked} = '0;
    foreach (sec[i]) sec[i] = 16'hffff;
  end

  // Boot block test
  function automatic bit boot(input logic [ADDR_W-1:0] a);
    return BOOT_AT_TOP ? a >= TOP_BOOT_FIRST : a <= BOTTOM_BOOT_LAST;
  endfunction : boot

  // Read value for the current mode
  function automatic logic [15:0] rd(input logic [ADDR_W-1:0] a);
    if (busy > 0) return {9'h000, tog, 6'h00};
    if (mode == M_ID) return a[0] ? DEV_ID : MAKER_ID;
    if (mode == M_CFI) return 16'h0051; // Arbitrary table word
    if (mode == M_SEC) return (a < 136) ? sec[a[7:0]] : 16'hffff;
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hffff;
  endfunction : rd

  // Command decoder; only the low byte counts
  task automatic cmd(input logic [ADDR_W-1:0] ca, input logic [DATA_W-1:0] cw);
    logic [7:0] cd;
    bit st, ok;
    cd = cw[7:0];
    st = (ca == UNLOCK_ADDR1 && cd == UNLOCK_CODE1);
    ok = pins.wp_n || !boot(ca); // Protect pin low refuses boot block
    case (stg)
      0: begin // Anything but an unlock or short CFI entry is ignored
        stg = st ? 1 : 0;
        if (ca == SHORT_CFI_ADDR && cd == SHORT_CFI_CODE) mode = M_CFI;
      end
      1, 4: stg = (ca == UNLOCK_ADDR2 && cd == UNLOCK_CODE2) ? stg + 1 : int'(st);
      2: begin
        stg = int'(st);
        if (ca == UNLOCK_ADDR1) begin
          case (cd)
            PROGRAM_CODE: stg = 6; // Guard always on
            ERASE_SETUP_CODE: stg = 3;
            SEC_PROGRAM_CODE: stg = 7;
            SEC_LOCK_CODE: stg = 8;
            ID_ENTRY_CODE: mode = M_ID;
            CFI_ENTRY_CODE: mode = M_CFI;
            SEC_ENTRY_CODE: mode = M_SEC;
            EXIT_CODE: mode = M_ARR;
            default: ;
          endcase
        end
      end
      3: stg = st ? 4 : 0;
      5: begin // Sixth cycle picks the erase kind
        stg = 0;
        busy = 3;
        if (cd == CHIP_ERASE_CODE && pins.wp_n) mem.delete();
        else if ((cd == SECTOR_ERASE_CODE || cd == BLOCK_ERASE_CODE) && ok) mem.delete(int'(ca));
        else busy = 0;
      end
      6: begin // Word program
        stg = 0;
        busy = 3;
        if (ok) mem[int'(ca)] = cw;
      end
      7: begin // User security word, never once locked
        stg = 0;
        busy = 3;
        if (!locked && ca >= 8 && ca < 136) sec[ca[7:0]] = cw;
      end
      8: begin // Lock-out; no erase path exists
        stg = 0;
        locked = 1'b1;
      end
      default: stg = 0;
    endcase
  endtask : cmd

  // ------------------------------------------------------------
  // Pin behaviour
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!pins.rst_n) begin // Abort to read mode
      stg = 0;
      mode = M_ARR;
      busy = 0;
    end else if (!p.we_n && pins.we_n && !p.ce_n && p.oe_n && lowc >= 2 && busy == 0) begin
      cmd(p.addr, p.dq_o); // Clean pulse only
    end
    lowc = pins.we_n ? 0 : lowc + 1;
    if (p.oe_n && !pins.oe_n && busy > 0) begin // Each read while busy flips the bit
      tog = !tog;
      busy = busy - 1;
    end
    if (!pins.ce_n && !pins.oe_n) dq <= rd(pins.addr);
    else dq <= ~dq; // Released lines show the inverse
    p = pins;
  end
endmodule : fpmc_flash_model
`default_nettype wire

// >>> tb/fpmc_host_bench.sv
// Self-checking bench of the flash host controller against a flash model.
// Assumes the package, checker and flash model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module fpmc_host_bench;
  import fpmc_pkg::*;
  // ------------------------------------------------------------
  // Signals and table
  // ------------------------------------------------------------
  typedef struct packed {
    logic prot;
    fpmc_op_type op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] exp;
  } fpmc_row_type;
  localparam logic [15:0] MAKER = 16'h005a; // Arbitrary value
  localparam logic [15:0] DEV = 16'h7c31; // Arbitrary value
  localparam fpmc_row_type ROWS [0:32] = '{
    '{0, OP_PROGRAM, 20'h00100, 16'h1234, 0}, '{0, OP_READ, 20'h00100, 0, 16'h1234},
    '{0, OP_SECTOR_ERASE, 20'h00100, 0, 0}, '{0, OP_READ, 20'h00100, 0, 16'hffff},
    '{0, OP_PROGRAM, 20'h00200, 16'h00ff, 0}, '{0, OP_BLOCK_ERASE, 20'h00200, 0, 0},
    '{0, OP_READ, 20'h00200, 0, 16'hffff}, '{0, OP_PROGRAM, 20'h00300, 16'ha5a5, 0},
    '{0, OP_CHIP_ERASE, 0, 0, 0}, '{0, OP_READ, 20'h00300, 0, 16'hffff},
    '{0, OP_ID_ENTRY, 0, 0, 0}, '{0, OP_READ, 20'h00000, 0, MAKER},
    '{0, OP_READ, 20'h00001, 0, DEV}, '{0, OP_EXIT, 0, 0, 0},
    '{0, OP_READ, 20'h00000, 0, 16'hffff}, '{0, OP_CFI_ENTRY, 0, 0, 0},
    '{0, OP_READ, 20'h00010, 0, 16'h0051}, '{0, OP_EXIT, 0, 0, 0},
    '{0, OP_CFI_SHORT, 0, 0, 0}, '{0, OP_READ, 20'h00010, 0, 16'h0051},
    '{0, OP_READ, 20'h00011, 0, 16'h0051}, '{0, OP_EXIT, 0, 0, 0},
    '{0, OP_READ, 20'h00010, 0, 16'hffff}, '{0, OP_SEC_PROGRAM, 20'h00010, 16'hbeef, 0},
    '{0, OP_SEC_LOCK, 0, 0, 0}, '{0, OP_SEC_PROGRAM, 20'h00010, 16'h1111, 0},
    '{0, OP_SEC_ENTRY, 0, 0, 0}, '{0, OP_READ, 20'h00010, 0, 16'hbeef},
    '{0, OP_EXIT, 0, 0, 0}, '{1, OP_PROGRAM, 20'h00010, 16'h5555, 0},
    '{1, OP_READ, 20'h00010, 0, 16'hffff}, '{0, OP_PROGRAM, 20'h00010, 16'h5555, 0},
    '{0, OP_READ, 20'h00010, 0, 16'h5555}};
  logic CORE_CLK, RESET_N, REQ_VALID, REQ_READY, RSP_VALID, PROTECT_BOOT; // Design pins
  fpmc_req_type REQ; // Request word
  logic [DATA_W-1:0] RSP_DATA, FL_DQ_I; // Answer and flash data
  fpmc_pins_type PINS; // Flash pins
  int fail_count, samples_checked, low_cyc; // Counters; flash reset low cycles

  fpmc_host i_fpmc_host (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
    .PROTECT_BOOT(PROTECT_BOOT), .FL_DQ_I(FL_DQ_I), .PINS(PINS));
  fpmc_flash_model #(.MAKER_ID(MAKER), .DEV_ID(DEV)) i_fpmc_flash_model (.clk(CORE_CLK),
    .pins(PINS), .dq(FL_DQ_I));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic conclude();
    $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  // Compares a data word
  task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t data %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  // Compares a flag
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // One request and a bounded wait for its answer
  task automatic run_op(input fpmc_op_type op, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d);
    int n;
    @(posedge CORE_CLK) #1;
    REQ_VALID = 1'b1;
    REQ = '{op: op, addr: a, data: d};
    do @(posedge CORE_CLK); while (REQ_READY !== 1'b1);
    #1 REQ_VALID = 1'b0;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (RSP_VALID !== 1'b1 && n < 4000);
    if (n >= 4000) chk_bit(1'b0, 1'b1); // No answer in time
  endtask : run_op

  // ------------------------------------------------------------
  // Clock, monitor, watchdog, tests
  // ------------------------------------------------------------
  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end

  // Counts cycles with the flash reset pin low
  always @(posedge CORE_CLK) if (PINS.rst_n === 1'b0) low_cyc++;

  // Cuts a hang short
  initial begin
    #100000;
    fail_count++;
    conclude();
  end

  initial begin
    {RESET_N, REQ_VALID, PROTECT_BOOT} = '0;
    REQ = '0;
    {fail_count, samples_checked, low_cyc} = '0;
    repeat (20) @(posedge CORE_CLK);
    #1 RESET_N = 1'b1;
    repeat (2) @(posedge CORE_CLK);
    foreach (ROWS[i]) begin
      #1 PROTECT_BOOT = ROWS[i].prot;
      run_op(ROWS[i].op, ROWS[i].addr, ROWS[i].data);
      if (ROWS[i].op == OP_READ) chk_data(RSP_DATA, ROWS[i].exp);
    end
    // Flash reset drops identification mode
    run_op(OP_ID_ENTRY, 0, 0);
    low_cyc = 0;
    run_op(OP_HW_RESET, 0, 0);
    chk_data(16'(low_cyc), 16'(RESET_PULSE_CYC));
    run_op(OP_READ, 20'h00000, 0);
    chk_data(RSP_DATA, 16'hffff);
    // Controller reset in the middle of a command sequence
    @(posedge CORE_CLK) #1;
    REQ_VALID = 1'b1;
    REQ = '{op: OP_PROGRAM, addr: 20'h00400, data: 16'habcd};
    @(posedge CORE_CLK) #1 REQ_VALID = 1'b0;
    repeat (30) @(posedge CORE_CLK);
    #1 RESET_N = 1'b0;
    repeat (4) @(posedge CORE_CLK);
    #1 chk_bit(PINS === PINS_IDLE, 1'b1);
    chk_bit(REQ_READY, 1'b0);
    RESET_N = 1'b1;
    repeat (2) @(posedge CORE_CLK);
    run_op(OP_PROGRAM, 20'h00400, 16'habcd); // Reissued by the user
    run_op(OP_READ, 20'h00400, 0);
    chk_data(RSP_DATA, 16'habcd);
    conclude();
  end
endmodule : fpmc_host_bench
`default_nettype wire
